// >>> verilog/urx_receiver.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
// Contract
// - Serial bits enter an internal shift register, least significant bit first.
// - Received buffer is a two-entry FIFO; a third word may be shifting meanwhile.
// - Word completing with FIFO full sets overrun, keeps FIFO, may interrupt.
// - Overrun clears only after status access then buffer read.
// - Data-available set while unread word held; cleared by status-then-buffer read.
// - Word moved into buffer with receive interrupt enable requests interrupt.
// - Break ends after programmed bits: framing error, zeros stored, idle set.
// - After break, wait for high line before searching for start bit.
// - Idle flag low from start detect until stop sampled, high otherwise.
// - Noise sets noise flag with data-available; word still transferred, no own interrupt.
// - Framing error when any expected stop bit samples low; buffered per word.
// - Parity error when enabled parity is wrong; buffered per word.
// - Interrupt merges transmit empty, transmit idle, receive, overrun, address, wake sources.
// - Interrupt request is a low-going pulse on each enabled condition.
// - Status flags read-only; writes ignored; only access sequences or events clear.
// - Address detect: receive interrupt only when highest received bit is one.
// - Receive-pin falling edge in idle-zero mode wakes, interrupts with both enables.
// - Bit level is a majority of three samples at sixteen times baud.
// - Nine-bit mode keeps the top bit in a separate ninth-bit status field.
module urx_receiver
	import urx_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line and system state
	input wire logic rx_pin,
	input wire logic idle_zero_mode,
	input wire logic tx_empty_in,
	input wire logic tx_idle_in,
	// Interrupt request, active low pulse
	output logic uart_irq_n
);

	// Address decode shared by the error response and the write side effects
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == URX_CTRL_OFF) || (a == URX_BAUD_OFF) || (a == URX_STAT_OFF) || (a == URX_DATA_OFF);
	endfunction

	logic [URX_CTRL_W-1:0] control_register_two_r;
	logic [15:0] baud_divider_r, div_cnt_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, uart_irq_n_r;
	logic rx_meta_r, rx_sync_r, rx_prev_r, tick_r;
	urx_state_t state_r;
	logic [3:0] os_cnt_r, bit_cnt_r;
	logic samp_a_r, samp_b_r;
	logic [8:0] rx_shift_register_r;
	logic frame_noise_r, frame_parity_error_flag_r, frame_framing_error_flag_r;
	logic [10:0] fifo_r [0:1];
	logic [1:0] fifo_cnt_r;
	logic overrun_flag_r, noise_flag_r, status_seen_r;
	logic push_r, ovr_event_r, addr_ok_r;
	logic tx_empty_prev_r, tx_idle_prev_r;

	logic acc_done, wr_done, rd_data, rd_stat;
	logic vote, vote_noise, vote_tick, end_tick, frame_done;
	logic [8:0] word_aligned;
	logic [3:0] bits_needed;
	logic pop, rx_idle_flag;
	logic [31:0] read_mux;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign uart_irq_n = uart_irq_n_r;

	// A transfer completes at the access edge that sees our registered ready
	assign acc_done = psel && penable && pready_r;
	assign wr_done = acc_done && pwrite && is_mapped(paddr);
	assign rd_data = acc_done && !pwrite && (paddr == URX_DATA_OFF);
	assign rd_stat = acc_done && !pwrite && (paddr == URX_STAT_OFF);
	// Pop needs the status access first, so stray data reads leave the word in place
	assign pop = rd_data && status_seen_r && (fifo_cnt_r != 2'h0);
	assign rx_idle_flag = (state_r == URX_SEARCH) || (state_r == URX_BRKWAIT);

	// APB handshake: one wait state so read data can come from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else if (psel && penable && !pready_r) begin
			pready_r <= 1'b1;
			pslverr_r <= !is_mapped(paddr);
			prdata_r <= pwrite ? 32'h00000000 : read_mux;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Read mux; status writes fall through untouched
	always_comb begin
		read_mux = 32'h00000000;
		case (paddr)
			URX_CTRL_OFF: read_mux[URX_CTRL_W-1:0] = control_register_two_r;
			URX_BAUD_OFF: read_mux[15:0] = baud_divider_r;
			URX_STAT_OFF: begin
				read_mux[URX_S_AVAIL] = (fifo_cnt_r != 2'h0);
				read_mux[URX_S_OVR] = overrun_flag_r;
				read_mux[URX_S_NOISE] = noise_flag_r;
				read_mux[URX_S_FRAMING_ERROR_FLAG] = fifo_r[0][9];
				read_mux[URX_S_PARITY_ERROR_FLAG] = fifo_r[0][10];
				read_mux[URX_S_IDLE] = rx_idle_flag;
				read_mux[URX_S_NINTH] = fifo_r[0][8];
			end
			URX_DATA_OFF: read_mux[7:0] = fifo_r[0][7:0];
			default: read_mux = 32'h00000000;
		endcase
	end

	// Writable configuration; the status word has no write path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_register_two_r <= URX_CTRL_RST;
			baud_divider_r <= URX_BAUD_RST;
		end else if (wr_done && paddr == URX_CTRL_OFF) begin
			control_register_two_r <= pwdata[URX_CTRL_W-1:0];
		end else if (wr_done && paddr == URX_BAUD_OFF) begin
			baud_divider_r <= pwdata[15:0];
		end
	end

	// Pin synchroniser; the second stage feeds the receiver, the third only the wake edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_meta_r <= rx_pin;
			rx_sync_r <= rx_meta_r;
			rx_prev_r <= rx_sync_r;
		end
	end

	// Oversampling tick: divider+1 clocks per tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (div_cnt_r >= baud_divider_r) begin
			div_cnt_r <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// Majority of three; disagreement flags noise
	assign vote = (samp_a_r & samp_b_r) | (samp_a_r & rx_sync_r) | (samp_b_r & rx_sync_r);
	assign vote_noise = !(samp_a_r == samp_b_r && samp_b_r == rx_sync_r);
	assign vote_tick = tick_r && (os_cnt_r == URX_VOTE_C);
	assign end_tick = tick_r && (os_cnt_r == URX_BIT_END);
	assign bits_needed = control_register_two_r[URX_C_NINE] ? 4'h9 : 4'h8;
	assign word_aligned = control_register_two_r[URX_C_NINE] ? rx_shift_register_r : {1'b0, rx_shift_register_r[8:1]};
	assign frame_done = vote_tick && ((state_r == URX_STOP1 && !control_register_two_r[URX_C_TWOSTOP])
		|| state_r == URX_STOP2);

	// Frame sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= URX_SEARCH;
			os_cnt_r <= 4'h0;
			bit_cnt_r <= 4'h0;
			samp_a_r <= 1'b1;
			samp_b_r <= 1'b1;
			rx_shift_register_r <= 9'h000;
			frame_noise_r <= 1'b0;
			frame_parity_error_flag_r <= 1'b0;
			frame_framing_error_flag_r <= 1'b0;
		end else if (!control_register_two_r[URX_C_RECEIVER_ENABLE]) begin
			state_r <= URX_SEARCH;
			os_cnt_r <= 4'h0;
			bit_cnt_r <= 4'h0;
		end else begin
			if (tick_r && os_cnt_r == URX_VOTE_A)
				samp_a_r <= rx_sync_r;
			if (tick_r && os_cnt_r == URX_VOTE_B)
				samp_b_r <= rx_sync_r;
			if (tick_r)
				os_cnt_r <= os_cnt_r + 4'h1;
			case (state_r)
				URX_SEARCH: begin
					if (!rx_sync_r) begin
						state_r <= URX_START;
						os_cnt_r <= 4'h0;
						frame_noise_r <= 1'b0;
						frame_parity_error_flag_r <= control_register_two_r[URX_C_PARODD];
						frame_framing_error_flag_r <= 1'b0;
					end
				end
				URX_START: begin
					if (vote_tick && vote)
						state_r <= URX_SEARCH;
					else if (end_tick) begin
						state_r <= URX_DATA;
						bit_cnt_r <= 4'h0;
					end
					if (vote_tick && vote_noise)
						frame_noise_r <= 1'b1;
				end
				URX_DATA: begin
					if (vote_tick) begin
						rx_shift_register_r <= {vote, rx_shift_register_r[8:1]};
						frame_parity_error_flag_r <= frame_parity_error_flag_r ^ vote;
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (vote_noise)
							frame_noise_r <= 1'b1;
					end
					if (end_tick && bit_cnt_r == bits_needed)
						state_r <= URX_STOP1;
				end
				URX_STOP1, URX_STOP2: begin
					if (vote_tick) begin
						if (!vote)
							frame_framing_error_flag_r <= 1'b1;
						if (vote_noise)
							frame_noise_r <= 1'b1;
					end
					if (frame_done)
						state_r <= (!vote || frame_framing_error_flag_r) ? URX_BRKWAIT : URX_SEARCH;
					else if (end_tick)
						state_r <= URX_STOP2;
				end
				URX_BRKWAIT: begin
					if (rx_sync_r)
						state_r <= URX_SEARCH;
				end
				default: state_r <= URX_SEARCH;
			endcase
		end
	end

	// Stop sampled: push, or flag overrun when both entries are taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_r[0] <= 11'h000;
			fifo_r[1] <= 11'h000;
			fifo_cnt_r <= 2'h0;
			push_r <= 1'b0;
			ovr_event_r <= 1'b0;
			addr_ok_r <= 1'b0;
		end else begin
			push_r <= 1'b0;
			ovr_event_r <= 1'b0;
			if (frame_done && fifo_cnt_r == URX_FIFO_DEPTH && !pop) begin
				ovr_event_r <= 1'b1;
			end else if (frame_done) begin
				push_r <= 1'b1;
				addr_ok_r <= word_aligned[bits_needed[0] ? 8 : 7];
				if (pop && fifo_cnt_r == 2'h2) begin
					fifo_r[0] <= fifo_r[1];
					fifo_r[1] <= {control_register_two_r[URX_C_PAREN] && frame_parity_error_flag_r,
						frame_framing_error_flag_r || !vote, word_aligned};
				end else if (pop || fifo_cnt_r == 2'h0) begin
					fifo_r[0] <= {control_register_two_r[URX_C_PAREN] && frame_parity_error_flag_r, frame_framing_error_flag_r || !vote, word_aligned};
				end else begin
					fifo_r[1] <= {control_register_two_r[URX_C_PAREN] && frame_parity_error_flag_r, frame_framing_error_flag_r || !vote, word_aligned};
				end
				fifo_cnt_r <= pop ? fifo_cnt_r : fifo_cnt_r + 2'h1;
			end else if (pop) begin
				fifo_r[0] <= fifo_r[1];
				fifo_cnt_r <= fifo_cnt_r - 2'h1;
			end
		end
	end

	// Sticky flags and the status-then-data sequence; a set wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_flag_r <= 1'b0;
			noise_flag_r <= 1'b0;
			status_seen_r <= 1'b0;
		end else begin
			if (rd_stat)
				status_seen_r <= 1'b1;
			else if (rd_data)
				status_seen_r <= 1'b0;
			if (frame_done && fifo_cnt_r == URX_FIFO_DEPTH && !pop)
				overrun_flag_r <= 1'b1;
			else if (rd_data && status_seen_r)
				overrun_flag_r <= 1'b0;
			if (frame_done && (frame_noise_r || vote_noise))
				noise_flag_r <= 1'b1;
			else if (rd_data && status_seen_r)
				noise_flag_r <= 1'b0;
		end
	end

	// Interrupt merge; each source is an edge, so the output is a one-cycle low pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_irq_n_r <= 1'b1;
			tx_empty_prev_r <= 1'b0;
			tx_idle_prev_r <= 1'b0;
		end else begin
			tx_empty_prev_r <= tx_empty_in;
			tx_idle_prev_r <= tx_idle_in;
			uart_irq_n_r <= !(
				(control_register_two_r[URX_C_RIE] && push_r
					&& (!control_register_two_r[URX_C_ADDR] || addr_ok_r))
				|| (control_register_two_r[URX_C_RIE] && ovr_event_r)
				|| (control_register_two_r[URX_C_RIE] && control_register_two_r[URX_C_WAKE]
					&& idle_zero_mode && rx_prev_r && !rx_sync_r)
				|| (control_register_two_r[URX_C_TEIE] && tx_empty_in && !tx_empty_prev_r)
				|| (control_register_two_r[URX_C_TIIE] && tx_idle_in && !tx_idle_prev_r));
		end
	end

	// Checks
	sequence word_pushed_s;
		push_r && control_register_two_r[URX_C_RIE] && !control_register_two_r[URX_C_ADDR];
	endsequence
	sequence full_and_done_s;
		frame_done && fifo_cnt_r == 2'h2 && !pop;
	endsequence

	rx_irq_fires_a: assert property (@(posedge pclk) disable iff (!presetn) word_pushed_s |=> !uart_irq_n_r)
		else $error("receive interrupt missing");
	overrun_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
		full_and_done_s |=> overrun_flag_r && fifo_cnt_r == 2'h2 && $stable(fifo_r[0]))
		else $error("overrun handling wrong");
	overrun_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(overrun_flag_r) |-> $past(rd_data) && $past(status_seen_r))
		else $error("overrun cleared without sequence");
	fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn) fifo_cnt_r <= 2'h2)
		else $error("fifo count beyond depth");
	avail_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_cnt_r != 2'h0 && !pop |=> fifo_cnt_r != 2'h0)
		else $error("data available dropped");
	idle_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == URX_SEARCH && control_register_two_r[URX_C_RECEIVER_ENABLE] && !rx_sync_r |=> !rx_idle_flag)
		else $error("idle flag not low after start");
	break_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == URX_BRKWAIT && !rx_sync_r && control_register_two_r[URX_C_RECEIVER_ENABLE] |=> state_r == URX_BRKWAIT)
		else $error("break line taken as start");
	disable_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		!control_register_two_r[URX_C_RECEIVER_ENABLE] |=> state_r == URX_SEARCH)
		else $error("receiver not returned to search");
	irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		!uart_irq_n_r |-> $past(push_r) || $past(ovr_event_r) || $past(tx_empty_in) || $past(tx_idle_in)
		|| $past(!rx_sync_r))
		else $error("interrupt without source");
	stat_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == URX_STAT_OFF |=> $stable(overrun_flag_r) || overrun_flag_r)
		else $error("status write changed a flag");

endmodule

// >>> verilog/urx_pkg.sv
package urx_pkg;
	// Register byte offsets
	localparam logic [7:0] URX_CTRL_OFF = 8'h00;
	localparam logic [7:0] URX_BAUD_OFF = 8'h04;
	localparam logic [7:0] URX_STAT_OFF = 8'h08;
	localparam logic [7:0] URX_DATA_OFF = 8'h0C;
	// Control register field positions
	localparam int URX_C_RECEIVER_ENABLE = 0;
	localparam int URX_C_NINE = 1;
	localparam int URX_C_TWOSTOP = 2;
	localparam int URX_C_PAREN = 3;
	localparam int URX_C_PARODD = 4;
	localparam int URX_C_ADDR = 5;
	localparam int URX_C_RIE = 6;
	localparam int URX_C_WAKE = 7;
	localparam int URX_C_TEIE = 8;
	localparam int URX_C_TIIE = 9;
	localparam int URX_CTRL_W = 10;
	// Status register field positions
	localparam int URX_S_AVAIL = 0;
	localparam int URX_S_OVR = 1;
	localparam int URX_S_NOISE = 2;
	localparam int URX_S_FRAMING_ERROR_FLAG = 3;
	localparam int URX_S_PARITY_ERROR_FLAG = 4;
	localparam int URX_S_IDLE = 5;
	localparam int URX_S_NINTH = 6;
	// Reset values
	localparam logic [URX_CTRL_W-1:0] URX_CTRL_RST = 10'h000;
	localparam logic [15:0] URX_BAUD_RST = 16'h0000;
	// Oversampling: sixteen ticks a bit, votes at ticks 7, 8 and 9
	localparam logic [3:0] URX_VOTE_A = 4'h7;
	localparam logic [3:0] URX_VOTE_B = 4'h8;
	localparam logic [3:0] URX_VOTE_C = 4'h9;
	localparam logic [3:0] URX_BIT_END = 4'hF;
	localparam logic [1:0] URX_FIFO_DEPTH = 2'h2;
	typedef enum logic [2:0] {URX_SEARCH, URX_START, URX_DATA, URX_STOP1, URX_STOP2, URX_BRKWAIT} urx_state_t;
endpackage

// >>> tb/urx_serial_tx.sv
`timescale 1ns/100ps
// Remote transmitter on the receive line, one bit every BIT_CLKS clocks
module urx_serial_tx #(
	parameter int BIT_CLKS = 16
) (
	// Clock
	input wire logic pclk,
	// Serial line, idle high
	output logic rx_line
);
	// Line rests high, as a pulled-up idle line would
	initial begin
		rx_line = 1'b1;
	end

	// Hold one level for a number of clocks
	task automatic hold(input logic lvl, input int clks);
		rx_line <= lvl;
		repeat (clks) @(posedge pclk);
	endtask

	// Start bit, data LSB first, then stop bits; line left at last stop level
	task automatic send(input logic [8:0] d, input int nb, input int ns, input logic [1:0] stopv);
		int i;
		@(posedge pclk);
		hold(1'b0, BIT_CLKS);
		for (i = 0; i < nb; i++) begin
			hold(d[i], BIT_CLKS);
		end
		// Low stop levels only when a framing fault is commanded
		for (i = 0; i < ns; i++) begin
			hold(stopv[i], BIT_CLKS);
		end
	endtask
endmodule

// >>> tb/tb_uart_receiver_error_irq.sv
`timescale 1ns/100ps
module tb_uart_receiver_error_irq
	import urx_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, er, rx_pin, idle_zero_mode, tx_empty_in, tx_idle_in, uart_irq_n;
	int num_errors = 0;
	int compares = 0;
	int irq_cnt = 0;
	int irq_base = 0;
	logic [31:0] av, ov, fe, pe, idl, c, d;

	urx_receiver DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_pin(rx_pin), .idle_zero_mode(idle_zero_mode), .tx_empty_in(tx_empty_in),
		.tx_idle_in(tx_idle_in), .uart_irq_n(uart_irq_n));
	urx_serial_tx #(.BIT_CLKS(16)) tx (.pclk(pclk), .rx_line(rx_pin));

	// Clock, 8 ns period
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Count low cycles of the interrupt line; one per event
	always @(posedge pclk) begin
		if (uart_irq_n === 1'b0) irq_cnt++;
	end

	function automatic logic [31:0] bt(input int i);
		return 32'h0000_0001 << i;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("pready", 32'h0, 32'h1);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd & m, e);
	endtask

	// Status check, then data read that pops the head
	task automatic pop(input logic [31:0] m, input logic [31:0] e, input logic [7:0] dv);
		rchk("status", URX_STAT_OFF, m, e);
		rchk("data", URX_DATA_OFF, 32'h0000_00FF, {24'h0, dv});
	endtask

	task automatic irqs(input int n);
		chk("irq count", 32'(irq_cnt - irq_base), 32'(n));
		irq_base = irq_cnt;
	endtask

	task automatic tx8(input logic [8:0] dv, input int nb);
		tx.send(dv, nb, 1, 2'b01);
		repeat (4) @(posedge pclk);
	endtask

	task automatic stop_test();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard, well beyond the expected few thousand cycles
	initial begin
		repeat (30000) @(posedge pclk);
		num_errors++;
		stop_test();
	end

	initial begin
		{presetn, psel, penable, pwrite, idle_zero_mode, tx_empty_in, tx_idle_in} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		av = bt(URX_S_AVAIL);
		ov = bt(URX_S_OVR);
		fe = bt(URX_S_FRAMING_ERROR_FLAG);
		pe = bt(URX_S_PARITY_ERROR_FLAG);
		idl = bt(URX_S_IDLE);
		c = bt(URX_C_RECEIVER_ENABLE) | bt(URX_C_RIE);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, config, unmapped and read-only places
		rchk("ctrl", URX_CTRL_OFF, 32'hFFFF_FFFF, 32'h0);
		rchk("baud", URX_BAUD_OFF, 32'hFFFF_FFFF, 32'h0);
		apb(1'b1, URX_BAUD_OFF, 32'h0);
		apb(1'b1, URX_CTRL_OFF, c);
		rchk("ctrl", URX_CTRL_OFF, 32'hFFFF_FFFF, c);
		apb(1'b1, URX_STAT_OFF, 32'hFFFF_FFFF);
		rchk("status", URX_STAT_OFF, av | ov, 32'h0);
		rchk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0);
		chk("pslverr", {31'h0, er}, 32'h1);
		$display("test registers done");
		// Single frame: bit order, idle flag, data flag, interrupt
		irq_base = irq_cnt;
		fork
			tx8(9'h04B, 8);
			begin
				repeat (60) @(posedge pclk);
				rchk("idle", URX_STAT_OFF, idl, 32'h0);
			end
		join
		irqs(1);
		pop(av | idl | fe | pe, av | idl, 8'h4B);
		rchk("status", URX_STAT_OFF, av, 32'h0);
		$display("test single frame done");
		// Three frames unread: overrun, FIFO order, clear sequence
		tx8(9'h011, 8);
		tx8(9'h022, 8);
		tx8(9'h033, 8);
		irqs(3);
		pop(av | ov, av | ov, 8'h11);
		rchk("data", URX_DATA_OFF, 32'hFF, 32'h22);
		pop(av | ov, av, 8'h22);
		rchk("status", URX_STAT_OFF, av, 32'h0);
		$display("test overrun done");
		// Parity, even then odd: good word then flipped parity bit
		for (int odd = 0; odd < 2; odd++) begin
			apb(1'b1, URX_CTRL_OFF, c | bt(URX_C_PAREN) | (odd ? bt(URX_C_PARODD) : 32'h0));
			d = {24'h0, (^7'h35) ^ odd[0], 7'h35};
			tx8({1'b0, d[7:0]}, 8);
			tx8({1'b0, d[7:0] ^ 8'h80}, 8);
			pop(av | pe, av, d[7:0]);
			pop(av | pe, av | pe, d[7:0] ^ 8'h80);
		end
		$display("test parity done");
		// Two stop bits: second stop low gives framing error
		apb(1'b1, URX_CTRL_OFF, c | bt(URX_C_TWOSTOP));
		tx.send(9'h05A, 8, 2, 2'b01);
		tx.hold(1'b1, 32);
		tx8(9'h0A5, 8);
		pop(av | fe, av | fe, 8'h5A);
		pop(av | fe, av, 8'hA5);
		$display("test stop bits done");
		// Long break, then a normal frame
		apb(1'b1, URX_CTRL_OFF, c);
		irq_base = irq_cnt;
		tx.send(9'h000, 8, 1, 2'b00);
		tx.hold(1'b0, 300);
		tx.hold(1'b1, 32);
		tx8(9'h066, 8);
		irqs(2);
		pop(av | fe | idl, av | fe | idl, 8'h00);
		pop(av | fe, av, 8'h66);
		rchk("status", URX_STAT_OFF, av, 32'h0);
		$display("test break done");
		// Glitch on the middle vote of bit 0: word kept, noise flagged, one interrupt
		irq_base = irq_cnt;
		tx.hold(1'b0, 16);
		tx.hold(1'b1, 9);
		tx.hold(1'b0, 1);
		tx.hold(1'b1, 6);
		tx.hold(1'b0, 112);
		tx.hold(1'b1, 20);
		irqs(1);
		pop(av | bt(URX_S_NOISE), av | bt(URX_S_NOISE), 8'h01);
		rchk("noise", URX_STAT_OFF, bt(URX_S_NOISE), 32'h0);
		$display("test noise done");
		// Nine-bit word: top bit in status
		apb(1'b1, URX_CTRL_OFF, c | bt(URX_C_NINE));
		tx8(9'h1A5, 9);
		pop(av | bt(URX_S_NINTH), av | bt(URX_S_NINTH), 8'hA5);
		$display("test nine bit done");
		// Address detect: interrupt only with top bit set
		apb(1'b1, URX_CTRL_OFF, c | bt(URX_C_ADDR));
		irq_base = irq_cnt;
		tx8(9'h012, 8);
		irqs(0);
		tx8(9'h092, 8);
		irqs(1);
		pop(av, av, 8'h12);
		pop(av, av, 8'h92);
		$display("test address detect done");
		// Wake-up edge with and without wake enable, receiver off
		idle_zero_mode <= 1'b1;
		for (int w = 1; w >= 0; w--) begin
			apb(1'b1, URX_CTRL_OFF, bt(URX_C_RIE) | (w ? bt(URX_C_WAKE) : 32'h0));
			irq_base = irq_cnt;
			tx.hold(1'b0, 20);
			tx.hold(1'b1, 20);
			irqs(w);
		end
		idle_zero_mode <= 1'b0;
		$display("test wake done");
		// Transmit sources: enabled empty edge, masked idle edge
		apb(1'b1, URX_CTRL_OFF, bt(URX_C_TEIE));
		irq_base = irq_cnt;
		tx_empty_in <= 1'b1;
		repeat (6) @(posedge pclk);
		irqs(1);
		tx_idle_in <= 1'b1;
		repeat (6) @(posedge pclk);
		irqs(0);
		// Idle source with its own enable: a fresh rising edge interrupts
		apb(1'b1, URX_CTRL_OFF, bt(URX_C_TIIE));
		tx_idle_in <= 1'b0;
		repeat (3) @(posedge pclk);
		tx_idle_in <= 1'b1;
		repeat (6) @(posedge pclk);
		irqs(1);
		$display("test transmit sources done");
		stop_test();
	end
endmodule
